/* core/relay_feed_timer_control.sv */
// Relay feed timer control: bleed-then-feed, percent timer, biocide timer
`timescale 1ns/10ps
// Operation
// - Feed runs percentage of bleed time
// - Feed owed per bleed capped at limit
// - Reset-timer drops owed feed time
// - Daily on-time over max forces off, alarms
// - Midnight clears alarm, re-enables relay
// - Hand at timeout reverts prior selection
// - Reset-output-timeout suspends max for today
// - Percent mode: on percent of period
// - Spike switches to spike set point
// - Prebleed, biocide add, then bleed lockout
// - Prebleed ends on time or conductivity
// - Overlapping biocide event skipped, alarms
// - Interlock forces off, timers keep running
// - Activate-with forces on, timers unchanged
// - Add fully interlocked sets skipped alarm
// - Skipped alarm clears when relay energises
// - Expose phase time left, week, day
module relay_feed_timer_control
	import relay_timer_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        bleed_active,
	input  wire logic        cond_above_target,
	input  wire logic        cond_above_setpoint,
	input  wire logic        cond_above_spike,
	input  wire logic        interlock,
	input  wire logic        activate_with,
	input  wire logic        midnight,
	input  wire logic [2:0]  week_number,
	input  wire logic [2:0]  day_of_week,
	output logic             relay_out,
	output logic             bleed_block,
	output logic             bleed_request,
	output logic             irq
);
	typedef enum {PH_IDLE, PH_PREBLEED, PH_ADD, PH_LOCKOUT} phase_e;

	logic [31:0] tick_cnt;
	logic        tick;
	logic [31:0] ctrl, percent, feed_limit, daily_max, period, duration, prebleed, lockout, spike_time;
	logic [ST_WIDTH-1:0] status, mask;
	logic [2:0]  sync_bleed, sync_cond, sync_sp, sync_spk, sync_il, sync_aw, sync_mid;
	logic        bleed_s, cond_s, sp_s, spk_s, il_s, aw_s, mid_s, mid_d;
	logic [31:0] bleed_acc, feed_owed, feed_acc, on_total, phase_left, spike_left, period_cnt;
	logic [1:0]  hand_off_auto_state, hoa_prior;
	logic        max_hit, max_suspend, add_seen, spike_on, auto_on, relay_raw;
	phase_e      phase;
	logic        cmd_we, mid_evt;
	logic [ST_WIDTH-1:0] st_set;

	mode_e mode;
	assign mode    = mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
	assign cmd_we  = avs_write && !avs_waitrequest && avs_address == ADDR_CMD;
	assign mid_evt = mid_s && !mid_d;

	always_ff @(posedge clk_sys) begin
		if (reset || tick_cnt == TICK_DIV - 1) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
		tick <= !reset && tick_cnt == TICK_DIV - 1;
	end

	// Pin inputs: a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{sync_bleed, sync_cond, sync_sp, sync_spk, sync_il, sync_aw, sync_mid} <= '0;
			{bleed_s, cond_s, sp_s, spk_s, il_s, aw_s, mid_s, mid_d} <= '0;
		end else begin
			sync_bleed <= {sync_bleed[1:0], bleed_active};
			sync_cond  <= {sync_cond[1:0], cond_above_target};
			sync_sp    <= {sync_sp[1:0], cond_above_setpoint};
			sync_spk   <= {sync_spk[1:0], cond_above_spike};
			sync_il    <= {sync_il[1:0], interlock};
			sync_aw    <= {sync_aw[1:0], activate_with};
			sync_mid   <= {sync_mid[1:0], midnight};
			if (sync_bleed[2] == sync_bleed[1]) bleed_s <= sync_bleed[2];
			if (sync_cond[2] == sync_cond[1]) cond_s <= sync_cond[2];
			if (sync_sp[2] == sync_sp[1]) sp_s <= sync_sp[2];
			if (sync_spk[2] == sync_spk[1]) spk_s <= sync_spk[2];
			if (sync_il[2] == sync_il[1]) il_s <= sync_il[2];
			if (sync_aw[2] == sync_aw[1]) aw_s <= sync_aw[2];
			if (sync_mid[2] == sync_mid[1]) mid_s <= sync_mid[2];
			mid_d <= mid_s;
		end
	end

	// Register bus: one wait cycle per access
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl       <= CTRL_RESET;
			percent    <= '0;
			feed_limit <= '0;
			daily_max  <= '0;
			period     <= '0;
			duration   <= '0;
			prebleed   <= '0;
			lockout    <= '0;
			spike_time <= '0;
			mask       <= '0;
		end else if (avs_write && !avs_waitrequest) begin
			unique case (avs_address)
				ADDR_CTRL:       ctrl <= avs_writedata;
				ADDR_MASK:       mask <= avs_writedata[ST_WIDTH-1:0];
				ADDR_PERCENT:    percent <= avs_writedata;
				ADDR_FEED_LIMIT: feed_limit <= avs_writedata;
				ADDR_DAILY_MAX:  daily_max <= avs_writedata;
				ADDR_PERIOD:     period <= avs_writedata;
				ADDR_DURATION:   duration <= avs_writedata;
				ADDR_PREBLEED:   prebleed <= avs_writedata;
				ADDR_LOCKOUT:    lockout <= avs_writedata;
				ADDR_SPIKE_TIME: spike_time <= avs_writedata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			avs_readdata <= '0;
		end else begin
			unique case (avs_address)
				ADDR_CTRL:       avs_readdata <= {ctrl[31:4], hand_off_auto_state, ctrl[1:0]};
				ADDR_STATUS:     avs_readdata <= 32'(status);
				ADDR_MASK:       avs_readdata <= 32'(mask);
				ADDR_PERCENT:    avs_readdata <= percent;
				ADDR_FEED_LIMIT: avs_readdata <= feed_limit;
				ADDR_DAILY_MAX:  avs_readdata <= daily_max;
				ADDR_PERIOD:     avs_readdata <= period;
				ADDR_DURATION:   avs_readdata <= duration;
				ADDR_PREBLEED:   avs_readdata <= prebleed;
				ADDR_LOCKOUT:    avs_readdata <= lockout;
				ADDR_SPIKE_TIME: avs_readdata <= spike_time;
				ADDR_PHASE_LEFT: avs_readdata <= (mode == MODE_BLEED_FEED) ? feed_owed : phase_left;
				ADDR_CALENDAR:   avs_readdata <= {24'h00_0000, 1'b0, week_number, 1'b0, day_of_week};
				ADDR_ON_TOTAL:   avs_readdata <= on_total;
				default:         avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Hand selection with remembered prior state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hand_off_auto_state       <= HOA_OFF;
			hoa_prior <= HOA_OFF;
		end else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL) begin
			hand_off_auto_state <= avs_writedata[CTRL_HOA_LSB +: 2];
			if (avs_writedata[CTRL_HOA_LSB +: 2] == HOA_HAND && hand_off_auto_state != HOA_HAND) hoa_prior <= hand_off_auto_state;
		end else if (st_set[ST_DAILY_MAX] && hand_off_auto_state == HOA_HAND) begin
			hand_off_auto_state <= hoa_prior;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || cmd_we && avs_writedata[CMD_RESET_TIMER]) begin
			bleed_acc <= '0;
			feed_owed <= '0;
			feed_acc  <= '0;
		end else if (mode == MODE_BLEED_FEED && tick) begin
			if (bleed_s) begin
				bleed_acc <= bleed_acc + 32'h0000_0001;
				if (bleed_acc == 32'h0000_0000) feed_acc <= '0;
			end else if (bleed_acc != 0) begin
				bleed_acc <= '0;
				if (32'((64'(bleed_acc) * 64'(percent)) / 64'd100) > feed_limit) begin
					feed_owed <= feed_limit;
				end else begin
					feed_owed <= 32'((64'(bleed_acc) * 64'(percent)) / 64'd100);
				end
			end else if (feed_owed != 0) begin
				feed_owed <= feed_owed - 32'h0000_0001;
				feed_acc  <= feed_acc + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || mode != MODE_PERCENT) begin
			period_cnt <= '0;
		end else if (tick) begin
			period_cnt <= (period_cnt + 32'h0000_0001 >= period) ? '0 : period_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || mode != MODE_BIOCIDE) begin
			phase      <= PH_IDLE;
			phase_left <= '0;
			add_seen   <= 1'b0;
		end else if (phase == PH_IDLE) begin
			if (cmd_we && avs_writedata[CMD_BIO_EVENT]) begin
				add_seen <= 1'b0;
				if (prebleed != 0) begin
					phase      <= PH_PREBLEED;
					phase_left <= prebleed;
				end else begin
					phase      <= PH_ADD;
					phase_left <= duration;
				end
			end
		end else begin
			if (phase == PH_ADD && relay_out) add_seen <= 1'b1;
			if (phase == PH_PREBLEED && ctrl[CTRL_COND_EN] && !cond_s) begin
				phase      <= PH_ADD;
				phase_left <= duration;
			end else if (tick) begin
				if (phase_left > 1) begin
					phase_left <= phase_left - 32'h0000_0001;
				end else begin
					unique case (phase)
						PH_PREBLEED: begin
							phase      <= PH_ADD;
							phase_left <= duration;
						end
						PH_ADD: begin
							phase      <= PH_LOCKOUT;
							phase_left <= lockout;
						end
						default: begin
							phase      <= PH_IDLE;
							phase_left <= '0;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			spike_left <= '0;
		end else if (cmd_we && avs_writedata[CMD_SPIKE_EVENT]) begin
			spike_left <= spike_time;
		end else if (tick && spike_left != 0) begin
			spike_left <= spike_left - 32'h0000_0001;
		end
	end
	assign spike_on = spike_left != 0;

	always_comb begin
		unique case (mode)
			MODE_BLEED_FEED: auto_on = feed_owed != 0 && !bleed_s;
			MODE_PERCENT:    auto_on = 32'((64'(period_cnt) * 64'd100)) < 32'((64'(period) * 64'(percent)));
			MODE_BIOCIDE:    auto_on = phase == PH_ADD || (phase == PH_IDLE && (spike_on ? !spk_s : !sp_s));
			default:         auto_on = 1'b0;
		endcase
		relay_raw = aw_s || (!il_s && !max_hit &&
			(hand_off_auto_state == HOA_HAND || (hand_off_auto_state == HOA_AUTO && auto_on)));
	end

	always_ff @(posedge clk_sys) begin
		if (reset || mid_evt) begin
			on_total    <= '0;
			max_hit     <= 1'b0;
			max_suspend <= 1'b0;
		end else begin
			if (tick && relay_out && (hand_off_auto_state == HOA_HAND || hand_off_auto_state == HOA_AUTO)) on_total <= on_total + 32'h0000_0001;
			if (!max_suspend && daily_max != 0 && on_total > daily_max) max_hit <= 1'b1;
			if (cmd_we && avs_writedata[CMD_RESET_OUT]) begin
				max_suspend <= 1'b1;
				max_hit     <= 1'b0;
			end
		end
	end

	always_comb begin
		st_set = '0;
		st_set[ST_DAILY_MAX] = !max_hit && !max_suspend && daily_max != 0 && on_total > daily_max;
		st_set[ST_SKIPPED] = (cmd_we && avs_writedata[CMD_BIO_EVENT] && phase != PH_IDLE) ||
			(phase == PH_ADD && tick && phase_left <= 1 && !add_seen && !relay_out);
	end

	// Status is write-one-to-clear; a set in the same cycle wins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			status <= '0;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == ADDR_STATUS) begin
				status <= (status & ~avs_writedata[ST_WIDTH-1:0]) | st_set;
			end else begin
				status <= status | st_set;
			end
			if (mid_evt && !st_set[ST_DAILY_MAX]) status[ST_DAILY_MAX] <= 1'b0;
			if (relay_raw && !relay_out && !st_set[ST_SKIPPED]) status[ST_SKIPPED] <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			relay_out     <= 1'b0;
			bleed_block   <= 1'b0;
			bleed_request <= 1'b0;
			irq           <= 1'b0;
		end else begin
			relay_out     <= relay_raw;
			bleed_block   <= phase == PH_LOCKOUT;
			bleed_request <= phase == PH_PREBLEED;
			irq           <= |(status & mask);
		end
	end

	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (reset)
		tick |=> !tick) else $error("tick two cycles running");
	a_interlock_off: assert property (@(posedge clk_sys) disable iff (reset)
		il_s && !aw_s |=> !relay_out) else $error("relay on under interlock");
	a_force_on: assert property (@(posedge clk_sys) disable iff (reset)
		aw_s |=> relay_out) else $error("force did not energise relay");
	a_max_off: assert property (@(posedge clk_sys) disable iff (reset)
		max_hit && !aw_s |=> !relay_out) else $error("relay on past daily max");
	a_max_alarm: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(max_hit) |-> status[ST_DAILY_MAX]) else $error("daily max alarm missing");
	a_midnight_clr: assert property (@(posedge clk_sys) disable iff (reset)
		mid_evt |=> !max_hit) else $error("midnight did not clear limit");
	a_suspend_max: assert property (@(posedge clk_sys) disable iff (reset)
		max_suspend && !mid_evt |=> !max_hit) else $error("limit enforced while suspended");
	a_reset_timer: assert property (@(posedge clk_sys) disable iff (reset)
		cmd_we && avs_writedata[CMD_RESET_TIMER] |=> feed_owed == 0) else $error("feed owed kept");
	a_feed_cap: assert property (@(posedge clk_sys) disable iff (reset)
		mode == MODE_BLEED_FEED && $changed(feed_owed) && $past(feed_owed) == 0 |-> feed_owed <= feed_limit)
		else $error("feed owed above limit");
	a_overlap_skip: assert property (@(posedge clk_sys) disable iff (reset)
		cmd_we && avs_writedata[CMD_BIO_EVENT] && phase != PH_IDLE |=> status[ST_SKIPPED])
		else $error("overlap not flagged");
	a_lockout_block: assert property (@(posedge clk_sys) disable iff (reset)
		phase == PH_LOCKOUT |=> bleed_block) else $error("bleed not blocked");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
		|(status & mask) |=> irq) else $error("irq not raised");

	c_biocide_run: cover property (@(posedge clk_sys) phase == PH_ADD ##1 phase == PH_LOCKOUT);
	c_daily_max:   cover property (@(posedge clk_sys) $rose(max_hit));
	c_skipped:     cover property (@(posedge clk_sys) $rose(status[ST_SKIPPED]));
	c_feed_run:    cover property (@(posedge clk_sys) mode == MODE_BLEED_FEED && feed_owed != 0 && relay_out);
endmodule : relay_feed_timer_control

/* core/relay_timer_pkg.sv */
// Constants and types for the relay feed timer control block
package relay_timer_pkg;
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned TICK_PERIOD_S   = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam logic [7:0]  ADDR_MASK       = 8'h08;
	localparam logic [7:0]  ADDR_CMD        = 8'h0C;
	localparam logic [7:0]  ADDR_PERCENT    = 8'h10;
	localparam logic [7:0]  ADDR_FEED_LIMIT = 8'h14;
	localparam logic [7:0]  ADDR_DAILY_MAX  = 8'h18;
	localparam logic [7:0]  ADDR_PERIOD     = 8'h1C;
	localparam logic [7:0]  ADDR_DURATION   = 8'h20;
	localparam logic [7:0]  ADDR_PREBLEED   = 8'h24;
	localparam logic [7:0]  ADDR_LOCKOUT    = 8'h28;
	localparam logic [7:0]  ADDR_SPIKE_TIME = 8'h2C;
	localparam logic [7:0]  ADDR_PHASE_LEFT = 8'h30;
	localparam logic [7:0]  ADDR_CALENDAR   = 8'h34;
	localparam logic [7:0]  ADDR_ON_TOTAL   = 8'h38;
	localparam int unsigned CTRL_MODE_LSB   = 0;
	localparam int unsigned CTRL_HOA_LSB    = 2;
	localparam int unsigned CTRL_COND_EN    = 4;
	localparam int unsigned CMD_RESET_TIMER = 0;
	localparam int unsigned CMD_RESET_OUT   = 1;
	localparam int unsigned CMD_BIO_EVENT   = 2;
	localparam int unsigned CMD_SPIKE_EVENT = 3;
	localparam int unsigned ST_DAILY_MAX    = 0;
	localparam int unsigned ST_SKIPPED      = 1;
	localparam int unsigned ST_WIDTH        = 2;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	typedef enum logic [1:0] {MODE_BLEED_FEED, MODE_PERCENT, MODE_BIOCIDE, MODE_OFF} mode_e;
	typedef enum logic [1:0] {HOA_OFF, HOA_AUTO, HOA_HAND, HOA_RSVD} hoa_e;
endpackage : relay_timer_pkg

/* test/relay_far_side.sv */
// Far-side model: bleed relay driver and conductivity sensor
`timescale 1ns/10ps
module relay_far_side #(
	parameter int DRAIN_CYCLES = 15
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic bleed_demand,
	input  wire logic bleed_request,
	input  wire logic bleed_block,
	output logic      bleed_active,
	output logic      cond_above_target
);
	int drained;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bleed_active <= 1'b0;
		end else begin
			bleed_active <= (bleed_demand | bleed_request) & ~bleed_block;
		end
	end
	// Water only thins after bleeding a while; concentrates again once bleed stops
	always_ff @(posedge clk_sys) begin
		if (reset || !bleed_active) begin
			drained <= 0;
		end else if (drained < DRAIN_CYCLES) begin
			drained <= drained + 1;
		end
	end
	assign cond_above_target = (drained < DRAIN_CYCLES);
endmodule : relay_far_side

/* test/tb_relay_feed_timer_control.sv */
// Self-checking testbench for the relay feed timer control block
`timescale 1ns/10ps
module tb_relay_feed_timer_control;
	import relay_timer_pkg::*;
	logic        clk_sys;
	logic        reset;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        bleed_demand;
	logic        bleed_active;
	logic        cond_above_target;
	logic        cond_setpoint;
	logic        cond_spike;
	logic        interlock;
	logic        activate_with;
	logic        midnight;
	logic        relay_out;
	logic        bleed_block;
	logic        bleed_request;
	logic        irq;
	logic [31:0] q;
	int          n_fail;
	int          checked;
	int          cycles;
	int          len;

	relay_feed_timer_control #(.TICK_DIV(10)) dut_u (.clk_sys(clk_sys), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.bleed_active(bleed_active), .cond_above_target(cond_above_target), .cond_above_setpoint(cond_setpoint),
		.cond_above_spike(cond_spike), .interlock(interlock), .activate_with(activate_with),
		.midnight(midnight), .week_number(3'h5), .day_of_week(3'h2), .relay_out(relay_out),
		.bleed_block(bleed_block), .bleed_request(bleed_request), .irq(irq));
	relay_far_side far_u (.clk_sys(clk_sys), .reset(reset), .bleed_demand(bleed_demand),
		.bleed_request(bleed_request), .bleed_block(bleed_block), .bleed_active(bleed_active),
		.cond_above_target(cond_above_target));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	// Hang guard well above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Only the bench timeout ends a stuck access
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	function automatic logic pick(input int s);
		return (s == 0) ? relay_out : ((s == 1) ? bleed_request : bleed_block);
	endfunction : pick

	task automatic wait_high(input int s);
		int n;
		n = 0;
		while (pick(s) !== 1'b1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : wait_high

	task automatic pulse_len(input int s);
		wait_high(s);
		len = 0;
		while (pick(s) === 1'b1 && len < 400) begin
			@(posedge clk_sys);
			len++;
		end
	endtask : pulse_len

	task automatic count_high(input int s, input int n);
		len = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if (pick(s) === 1'b1) len++;
		end
	endtask : count_high

	task automatic bleed(input int n);
		bleed_demand <= 1'b1;
		repeat (n) @(posedge clk_sys);
		bleed_demand <= 1'b0;
	endtask : bleed

	task automatic t_reset();
		rd(ADDR_CTRL);
		check("ctrl", q, CTRL_RESET);
		rd(ADDR_STATUS);
		check("status", q, 32'h0000_0000);
		rd(8'hFC);
		check("unmapped", q, 32'h0000_0000);
	endtask : t_reset

	task automatic t_daily();
		wr(ADDR_DAILY_MAX, 32'h0000_0003);
		wr(ADDR_CTRL, 32'h0000_0007);
		wr(ADDR_CTRL, 32'h0000_000B);
		repeat (80) @(posedge clk_sys);
		check("relay", 32'(relay_out), 32'h0000_0000);
		rd(ADDR_STATUS);
		check("daily alarm", 32'(q[ST_DAILY_MAX]), 32'h0000_0001);
		check("irq masked", 32'(irq), 32'h0000_0000);
		rd(ADDR_CTRL);
		check("selection", 32'(q[3:2]), 32'(HOA_AUTO));
		wr(ADDR_MASK, 32'h0000_0001);
		// Irq is registered behind the new mask
		@(posedge clk_sys);
		check("irq", 32'(irq), 32'h0000_0001);
		midnight <= 1'b1;
		repeat (3) @(posedge clk_sys);
		midnight <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(ADDR_STATUS);
		check("alarm at midnight", 32'(q[ST_DAILY_MAX]), 32'h0000_0000);
		check("irq cleared", 32'(irq), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_000B);
		wr(ADDR_CMD, 32'h0000_0002);
		repeat (60) @(posedge clk_sys);
		check("relay override", 32'(relay_out), 32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0007);
		wr(ADDR_DAILY_MAX, 32'h0000_0000);
	endtask : t_daily

	task automatic t_percent();
		wr(ADDR_PERIOD, 32'h0000_0004);
		wr(ADDR_PERCENT, 32'h0000_0032);
		wr(ADDR_CTRL, 32'h0000_0005);
		repeat (40) @(posedge clk_sys);
		count_high(0, 80);
		check("percent on", 32'(len), 32'd40);
	endtask : t_percent

	task automatic t_feed();
		wr(ADDR_CTRL, 32'h0000_0004);
		wr(ADDR_FEED_LIMIT, 32'h0000_000A);
		bleed(60);
		pulse_len(0);
		check("feed share", 32'(len >= 20 && len <= 40), 32'h0000_0001);
		wr(ADDR_FEED_LIMIT, 32'h0000_0002);
		bleed(80);
		pulse_len(0);
		check("feed cap", 32'(len >= 10 && len <= 30), 32'h0000_0001);
		bleed(80);
		wait_high(0);
		wr(ADDR_CMD, 32'h0000_0001);
		count_high(0, 40);
		check("feed dropped", 32'(len), 32'd0);
	endtask : t_feed

	task automatic t_bio();
		wr(ADDR_PREBLEED, 32'h0000_0003);
		wr(ADDR_DURATION, 32'h0000_0002);
		wr(ADDR_LOCKOUT, 32'h0000_0005);
		wr(ADDR_CTRL, 32'h0000_0006);
		wr(ADDR_CMD, 32'h0000_0004);
		pulse_len(1);
		check("prebleed", 32'(len >= 20 && len <= 40), 32'h0000_0001);
		pulse_len(0);
		check("add", 32'(len >= 10 && len <= 30), 32'h0000_0001);
		wait_high(2);
		rd(ADDR_PHASE_LEFT);
		check("time left", 32'(q != 32'h0000_0000), 32'h0000_0001);
		rd(ADDR_CALENDAR);
		check("calendar", q, 32'h0000_0052);
		wr(ADDR_CMD, 32'h0000_0004);
		rd(ADDR_STATUS);
		check("skipped", 32'(q[ST_SKIPPED]), 32'h0000_0001);
		wr(ADDR_STATUS, 32'h0000_0002);
		rd(ADDR_STATUS);
		check("skipped w1c", 32'(q[ST_SKIPPED]), 32'h0000_0000);
		repeat (60) @(posedge clk_sys);
		check("lockout over", 32'(bleed_block), 32'h0000_0000);
	endtask : t_bio

	task automatic t_cond();
		// Limit kept nonzero with target on
		wr(ADDR_PREBLEED, 32'h0000_0014);
		wr(ADDR_CTRL, 32'h0000_0016);
		wr(ADDR_CMD, 32'h0000_0004);
		pulse_len(1);
		check("prebleed to target", 32'(len >= 10 && len <= 30), 32'h0000_0001);
		repeat (100) @(posedge clk_sys);
	endtask : t_cond

	task automatic t_force();
		wr(ADDR_PREBLEED, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0006);
		interlock <= 1'b1;
		// Let the interlock clear the pin synchroniser before the add starts
		repeat (8) @(posedge clk_sys);
		wr(ADDR_CMD, 32'h0000_0004);
		count_high(0, 40);
		check("interlocked add", 32'(len), 32'd0);
		rd(ADDR_STATUS);
		check("add skipped", 32'(q[ST_SKIPPED]), 32'h0000_0001);
		repeat (60) @(posedge clk_sys);
		interlock <= 1'b0;
		activate_with <= 1'b1;
		wr(ADDR_CMD, 32'h0000_0004);
		repeat (40) @(posedge clk_sys);
		check("forced on", 32'(relay_out), 32'h0000_0001);
		activate_with <= 1'b0;
		repeat (10) @(posedge clk_sys);
		check("force off", 32'(relay_out), 32'h0000_0000);
		rd(ADDR_STATUS);
		check("skipped cleared", 32'(q[ST_SKIPPED]), 32'h0000_0000);
	endtask : t_force

	task automatic t_spike();
		// Lockout from the forced add must run out first
		repeat (40) @(posedge clk_sys);
		check("normal above", 32'(relay_out), 32'h0000_0000);
		cond_spike <= 1'b0;
		wr(ADDR_SPIKE_TIME, 32'h0000_0003);
		wr(ADDR_CMD, 32'h0000_0008);
		pulse_len(0);
		check("spike window", 32'(len >= 15 && len <= 35), 32'h0000_0001);
		cond_setpoint <= 1'b0;
		repeat (10) @(posedge clk_sys);
		check("normal below", 32'(relay_out), 32'h0000_0001);
		cond_setpoint <= 1'b1;
		cond_spike <= 1'b1;
	endtask : t_spike

	initial begin
		reset = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		bleed_demand = 1'b0;
		cond_setpoint = 1'b1;
		cond_spike = 1'b1;
		interlock = 1'b0;
		activate_with = 1'b0;
		midnight = 1'b0;
		n_fail = 0;
		checked = 0;
		cycles = 0;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_daily();
		t_percent();
		t_feed();
		t_bio();
		t_cond();
		t_force();
		t_spike();
		complete_run();
	end
endmodule : tb_relay_feed_timer_control
